// ### cdoc_regs.svh
// Register offsets, field positions, reset values and limits of the output clock path
// Contract
// R1 - Two status outputs show lock of the input loop and the output loop.
// R2 - First divider on oscillator, second forms primary, third divides primary into secondary.
// R3 - Driver mode bits 5:3: 000 both single-ended, 100 LVDS-like, 101 ECL, 11x undefined.
// R4 - Mode 001 drives positive pin only, 010 negative only, 011 tristates both.
// R5 - Single-ended family applies programmed polarity to each pin independently.
// R6 - Single-ended or low-voltage differential families take a weak or strong drive bit.
// R7 - Each driver control register has a power-down bit, independent of family.
// R8 - Without port control, family follows select pin: 0 low-voltage, 1 emitter-coupled.
// R9 - Pin-selected low-voltage differential mode still honours programmed drive strength.
// R10 - Both references absent enters holdover and freezes oscillator tuning.
// R11 - Holdover ends when a reference returns; input loop then resynchronises.
// R12 - Software must set charge-pump current to 25 uA for 19.44 MHz mode.
// R13 - Feedback integer 64..255, first divider 4..11, second and third 1..63.
// R14 - Reference integer 1..63 with modulator off, 3..63 with it on.
// R15 - Feedback numerator 0..1048575, modulus 1..1048575, twenty bits.
// R16 - Reference numerator signed -524288..524287, modulus 1..524287.
// R17 - Reference factor is integer plus half plus numerator over twice modulus.
// R18 - Bypassed reference modulator forces fractional part to zero.
// R19 - Feedback factor is integer plus numerator over modulus from its modulator.
// R20 - Software picks reference dividers so both give the same intermediate frequency.
// R21 - Charge-pump current register uses all eight bits, overriding default gain.
// R22 - Lock outputs are registered levels changing only on clock edges.
`ifndef CDOC_REGS_SVH
`define CDOC_REGS_SVH
`define CDOC_CHARGE_PUMP_CURRENT 8'h0A
`define CDOC_PRIMARY_DRIVER_CONTROL 8'h32
`define CDOC_SECONDARY_DRIVER_CONTROL 8'h34
`define CDOC_DRV_MODE_HI 5
`define CDOC_DRV_MODE_LO 3
`define CDOC_DRV_POL_P 0
`define CDOC_DRV_POL_N 1
`define CDOC_DRV_STRONG 2
`define CDOC_DRV_PDN 6
`define CDOC_DRV_PORT_CTRL 7
`define CDOC_CP_RESET 8'h00
`define CDOC_DRV_RESET 8'h00
`define CDOC_FIRST_MIN 8'h04
`define CDOC_FIRST_MAX 8'h0B
`define CDOC_OUTDIV_MIN 8'h01
`define CDOC_OUTDIV_MAX 8'h3F
`define CDOC_FB_INT_MIN 8'h40
`define CDOC_REF_INT_MIN_SDM 6'h03
`define CDOC_REF_INT_MIN 6'h01
`endif

// ### cdoc_pkg.sv
// Types shared by the output clock path
package cdoc_pkg;
	typedef enum logic [2:0] {
		CDOC_SE_BOTH = 3'h0,
		CDOC_SE_POS = 3'h1,
		CDOC_SE_NEG = 3'h2,
		CDOC_TRI_BOTH = 3'h3,
		CDOC_LVDS = 3'h4,
		CDOC_ECL = 3'h5,
		CDOC_UNDEF6 = 3'h6,
		CDOC_UNDEF7 = 3'h7
	} cdoc_mode_t;
	typedef enum logic [1:0] {CDOC_ACQUIRE, CDOC_LOCKED, CDOC_HOLDOVER} cdoc_ref_state_t;
endpackage

// ### cdoc_divider.sv
// Integer clock divider producing a one-cycle tick and a toggled clock level
`timescale 1ns/10ps
`default_nettype none
module cdoc_divider (
	input wire logic clk, // Source clock
	input wire logic resetn, // Async active-low reset
	input wire logic tick_in, // Source tick (divide events)
	input wire logic [7:0] ratio, // Division ratio, 0 treated as 1
	output logic tick_out, // One tick per ratio input ticks
	output logic level_out // Divided square level
);
	logic [7:0] cnt_r;
	logic [7:0] last;
	assign last = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
		end else if (tick_in) begin
			cnt_r <= (cnt_r >= last) ? 8'h00 : cnt_r + 8'h01;
		end
	end
	assign tick_out = tick_in && (cnt_r >= last);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_out <= 1'b0;
		end else if (tick_out) begin
			level_out <= ~level_out;
		end
	end
endmodule
`default_nettype wire

// ### cdoc_clock_divider_output_config.sv
// Output divider chain, driver configuration, lock status and holdover control
`timescale 1ns/10ps
`default_nettype none
`include "cdoc_regs.svh"
module cdoc_clock_divider_output_config (
	input wire logic clk, // Divided oscillator clock
	input wire logic resetn, // Async active-low reset
	input wire logic reg_we, // Register write strobe
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] reg_rdata, // Register read data
	input wire logic [7:0] first_output_divider, // First divider setting
	input wire logic [7:0] second_output_divider, // Second divider setting
	input wire logic [7:0] third_output_divider, // Third divider setting
	input wire logic [7:0] fb_int, // Feedback integer
	input wire logic [19:0] fb_frac, // Feedback numerator
	input wire logic [19:0] feedback_period_count, // Feedback modulus
	input wire logic [5:0] ref_int, // Reference integer
	input wire logic [19:0] ref_frac, // Reference signed numerator
	input wire logic [19:0] reference_period_count, // Reference modulus
	input wire logic ref_sdm_en, // Reference modulator active
	input wire logic driver_family_select_pin, // Family pin, asynchronous
	input wire logic ref_a_present, // Reference A present, asynchronous
	input wire logic ref_b_present, // Reference B present, asynchronous
	input wire logic in_loop_lock_raw, // Input loop phase detector lock, asynchronous
	input wire logic out_loop_lock_raw, // Output loop phase detector lock, asynchronous
	input wire logic [15:0] tune_word_in, // Live oscillator tuning from loop filter
	output logic [15:0] tune_word, // Tuning applied to oscillator
	output logic holdover, // Holdover active
	output logic input_loop_locked, // Input loop lock status pin
	output logic output_loop_locked, // Output loop lock status pin
	output logic settings_legal, // All divider settings within range
	output logic [20:0] ref_frac_eff, // Effective reference fraction numerator (x2 mod units)
	output logic [19:0] fb_frac_eff, // Effective feedback fraction numerator
	output logic [7:0] charge_pump, // Charge-pump current code
	output logic primary_clock_output, // Primary positive pin
	output logic primary_clock_output_n, // Primary negative pin
	output logic primary_oe_p, // Primary positive enable
	output logic primary_oe_n, // Primary negative enable
	output logic [1:0] primary_family, // 0 single-ended, 1 low-voltage, 2 emitter-coupled, 3 off
	output logic primary_strong, // Primary strong drive
	output logic secondary_clock_output, // Secondary positive pin
	output logic secondary_clock_output_n, // Secondary negative pin
	output logic secondary_oe_p, // Secondary positive enable
	output logic secondary_oe_n, // Secondary negative enable
	output logic [1:0] secondary_family, // Family code as primary
	output logic secondary_strong // Secondary strong drive
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] cp_r;
	logic [7:0] pdrv_r;
	logic [7:0] sdrv_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cp_r <= `CDOC_CP_RESET;
			pdrv_r <= `CDOC_DRV_RESET;
			sdrv_r <= `CDOC_DRV_RESET;
		end else if (reg_we) begin
			if (reg_addr == `CDOC_CHARGE_PUMP_CURRENT) cp_r <= reg_wdata; // R21
			if (reg_addr == `CDOC_PRIMARY_DRIVER_CONTROL) pdrv_r <= reg_wdata;
			if (reg_addr == `CDOC_SECONDARY_DRIVER_CONTROL) sdrv_r <= reg_wdata;
		end
	end
	assign charge_pump = cp_r; // R21 R12
	always_comb begin
		unique case (reg_addr)
			`CDOC_CHARGE_PUMP_CURRENT: reg_rdata = cp_r;
			`CDOC_PRIMARY_DRIVER_CONTROL: reg_rdata = pdrv_r;
			`CDOC_SECONDARY_DRIVER_CONTROL: reg_rdata = sdrv_r;
			default: reg_rdata = 8'h00;
		endcase
	end

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// References reset as present, so a reset alone never looks like a lost reference
			sync1_r <= 5'h0C;
			sync2_r <= 5'h0C;
		end else begin
			sync1_r <= {driver_family_select_pin, ref_a_present, ref_b_present,
				in_loop_lock_raw, out_loop_lock_raw};
			sync2_r <= sync1_r;
		end
	end
	logic fam_pin_s;
	logic ref_any_s;
	assign fam_pin_s = sync2_r[4];
	assign ref_any_s = sync2_r[3] | sync2_r[2];

	// ****************************************
	// Lock status
	// ****************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			input_loop_locked <= 1'b0;
			output_loop_locked <= 1'b0;
		end else begin
			input_loop_locked <= sync2_r[1] & ~holdover; // R1 R22
			output_loop_locked <= sync2_r[0]; // R1 R22
		end
	end

	// ****************************************
	// Holdover
	// ****************************************
	cdoc_pkg::cdoc_ref_state_t hst_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hst_r <= cdoc_pkg::CDOC_ACQUIRE;
		end else begin
			unique case (hst_r)
				cdoc_pkg::CDOC_ACQUIRE: begin
					if (!ref_any_s) hst_r <= cdoc_pkg::CDOC_HOLDOVER; // R10
					else if (sync2_r[1]) hst_r <= cdoc_pkg::CDOC_LOCKED;
				end
				cdoc_pkg::CDOC_LOCKED: begin
					if (!ref_any_s) hst_r <= cdoc_pkg::CDOC_HOLDOVER; // R10
				end
				cdoc_pkg::CDOC_HOLDOVER: begin
					if (ref_any_s) hst_r <= cdoc_pkg::CDOC_ACQUIRE; // R11
				end
				default: hst_r <= cdoc_pkg::CDOC_ACQUIRE;
			endcase
		end
	end
	assign holdover = (hst_r == cdoc_pkg::CDOC_HOLDOVER);
	// Tuning is tracked every cycle outside holdover while a reference is present, so the frozen value is the one just before both references read absent
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tune_word <= 16'h0000;
		end else if (!holdover && ref_any_s) begin
			tune_word <= tune_word_in; // R10 R11
		end
	end

	// ****************************************
	// Divider legality and fractions
	// ****************************************
	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
	logic ref_int_ok;
	logic ref_frac_ok;
	assign ref_int_ok = ref_sdm_en ? (ref_int >= `CDOC_REF_INT_MIN_SDM) :
		(ref_int >= `CDOC_REF_INT_MIN); // R14
	// Modulus must be nonzero and fit in 19 bits; the signed numerator is not range-checked
	assign ref_frac_ok = (reference_period_count != 20'h00000) &&
		!reference_period_count[19]; // R16
	assign settings_legal = in_range(fb_int, `CDOC_FB_INT_MIN, 8'hFF) && // R13
		in_range(first_output_divider, `CDOC_FIRST_MIN, `CDOC_FIRST_MAX) && // R13
		in_range(second_output_divider, `CDOC_OUTDIV_MIN, `CDOC_OUTDIV_MAX) && // R13
		in_range(third_output_divider, `CDOC_OUTDIV_MIN, `CDOC_OUTDIV_MAX) && // R13
		(feedback_period_count != 20'h00000) && // R15
		ref_int_ok && ref_frac_ok;
	// Reference fraction is modulus plus numerator over twice the modulus
	// Bypass acts as a numerator of minus the modulus, so the fraction is zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_frac_eff <= 21'h000000;
			fb_frac_eff <= 20'h00000;
		end else begin
			ref_frac_eff <= ref_sdm_en ? // R17
				21'({1'b0, reference_period_count} + {ref_frac[19], ref_frac}) :
				21'h000000; // R18
			fb_frac_eff <= fb_frac; // R19 R15
		end
	end

	// ****************************************
	// Divider chain
	// ****************************************
	logic t0;
	logic t1;
	logic lvl1;
	logic lvl2;
	cdoc_divider u_first (
		.clk(clk),
		.resetn(resetn),
		.tick_in(1'b1),
		.ratio(first_output_divider),
		.tick_out(t0),
		.level_out()
	);
	cdoc_divider u_second ( // R2
		.clk(clk),
		.resetn(resetn),
		.tick_in(t0),
		.ratio(second_output_divider),
		.tick_out(t1),
		.level_out(lvl1)
	);
	cdoc_divider u_third ( // R2
		.clk(clk),
		.resetn(resetn),
		.tick_in(t1),
		.ratio(third_output_divider),
		.tick_out(),
		.level_out(lvl2)
	);

	// ****************************************
	// Drivers
	// ****************************************
	function automatic logic [6:0] drive(input logic [7:0] cfg, input logic pin,
		input logic lvl);
		logic [2:0] m;
		logic p;
		logic n;
		logic ep;
		logic en;
		logic [1:0] fam;
		logic st;
		m = cfg[`CDOC_DRV_MODE_HI:`CDOC_DRV_MODE_LO];
		p = lvl;
		n = ~lvl;
		ep = 1'b1;
		en = 1'b1;
		fam = 2'h3;
		st = 1'b0;
		if (!cfg[`CDOC_DRV_PORT_CTRL]) begin
			fam = pin ? 2'h2 : 2'h1; // R8
			st = pin ? 1'b0 : cfg[`CDOC_DRV_STRONG]; // R9
		end else begin
			unique case (cdoc_pkg::cdoc_mode_t'(m))
				cdoc_pkg::CDOC_SE_BOTH, cdoc_pkg::CDOC_SE_POS,
				cdoc_pkg::CDOC_SE_NEG, cdoc_pkg::CDOC_TRI_BOTH: begin
					fam = 2'h0; // R3
					p = lvl ^ cfg[`CDOC_DRV_POL_P]; // R5
					n = lvl ^ cfg[`CDOC_DRV_POL_N]; // R5
					ep = (m == 3'h0) || (m == 3'h1); // R4
					en = (m == 3'h0) || (m == 3'h2); // R4
					st = cfg[`CDOC_DRV_STRONG]; // R6
				end
				cdoc_pkg::CDOC_LVDS: begin
					fam = 2'h1; // R3
					st = cfg[`CDOC_DRV_STRONG]; // R6
				end
				cdoc_pkg::CDOC_ECL: fam = 2'h2; // R3
				default: begin
					ep = 1'b0;
					en = 1'b0;
				end
			endcase
		end
		if (cfg[`CDOC_DRV_PDN]) begin
			ep = 1'b0; // R7
			en = 1'b0; // R7
			fam = 2'h3;
		end
		drive = {st, fam, en, ep, n, p};
	endfunction
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{primary_strong, primary_family, primary_oe_n, primary_oe_p,
				primary_clock_output_n, primary_clock_output} <= 7'h00;
			{secondary_strong, secondary_family, secondary_oe_n, secondary_oe_p,
				secondary_clock_output_n, secondary_clock_output} <= 7'h00;
		end else begin
			{primary_strong, primary_family, primary_oe_n, primary_oe_p,
				primary_clock_output_n, primary_clock_output} <= drive(pdrv_r, fam_pin_s, lvl1);
			{secondary_strong, secondary_family, secondary_oe_n, secondary_oe_p,
				secondary_clock_output_n, secondary_clock_output} <= drive(sdrv_r, fam_pin_s, lvl2);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_pdn_off;
		@(posedge clk) disable iff (!resetn)
		pdrv_r[`CDOC_DRV_PDN] |=> !primary_oe_p && !primary_oe_n;
	endproperty
	a_pdn_off: assert property (p_pdn_off) else $error("primary drives while powered down"); // R7
	property p_pin_family;
		@(posedge clk) disable iff (!resetn)
		!sdrv_r[`CDOC_DRV_PORT_CTRL] && !sdrv_r[`CDOC_DRV_PDN] |=>
			secondary_family == ($past(fam_pin_s) ? 2'h2 : 2'h1);
	endproperty
	a_pin_family: assert property (p_pin_family) else $error("pin family not followed"); // R8
	property p_hold_freeze;
		@(posedge clk) disable iff (!resetn)
		holdover |=> $stable(tune_word);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("tuning moved in holdover"); // R10
	sequence s_refs_lost;
		!ref_any_s ##1 !ref_any_s;
	endsequence
	property p_enter_hold;
		@(posedge clk) disable iff (!resetn)
		s_refs_lost |-> holdover;
	endproperty
	a_enter_hold: assert property (p_enter_hold) else $error("holdover not entered"); // R10
	property p_exit_hold;
		@(posedge clk) disable iff (!resetn)
		holdover && ref_any_s |=> !holdover;
	endproperty
	a_exit_hold: assert property (p_exit_hold) else $error("holdover not left"); // R11
	property p_lock_out;
		@(posedge clk) disable iff (!resetn)
		sync2_r[0] |=> output_loop_locked;
	endproperty
	a_lock_out: assert property (p_lock_out) else $error("output lock not shown"); // R1
	property p_tri_mode;
		@(posedge clk) disable iff (!resetn)
		pdrv_r[7:3] == 5'h13 |=> !primary_oe_p && !primary_oe_n;
	endproperty
	a_tri_mode: assert property (p_tri_mode) else $error("tristate mode drives"); // R4
	property p_bypass;
		@(posedge clk) disable iff (!resetn)
		!ref_sdm_en |=> ref_frac_eff == 21'h000000;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass fraction nonzero"); // R18
	property p_cp;
		@(posedge clk) disable iff (!resetn)
		reg_we && reg_addr == `CDOC_CHARGE_PUMP_CURRENT |=> charge_pump == $past(reg_wdata);
	endproperty
	a_cp: assert property (p_cp) else $error("charge pump write lost"); // R21
	property p_lvds_mode;
		@(posedge clk) disable iff (!resetn)
		pdrv_r[7:3] == 5'h14 |=> primary_family == 2'h1 && primary_oe_p && primary_oe_n;
	endproperty
	a_lvds_mode: assert property (p_lvds_mode) else $error("lvds mode wrong"); // R3
	property p_pin_strength;
		@(posedge clk) disable iff (!resetn)
		!pdrv_r[`CDOC_DRV_PORT_CTRL] && !pdrv_r[`CDOC_DRV_PDN] && !fam_pin_s |=>
			primary_strong == $past(pdrv_r[`CDOC_DRV_STRONG]);
	endproperty
	a_pin_strength: assert property (p_pin_strength) else $error("pin strength lost"); // R9
	property p_lock_in;
		@(posedge clk) disable iff (!resetn)
		!sync2_r[1] || holdover |=> !input_loop_locked;
	endproperty
	a_lock_in: assert property (p_lock_in) else $error("input lock shown falsely"); // R1
	property p_se_pol;
		@(posedge clk) disable iff (!resetn)
		pdrv_r[7:3] == 5'h10 |=> (primary_clock_output ^ primary_clock_output_n) ==
			$past(pdrv_r[`CDOC_DRV_POL_P] ^ pdrv_r[`CDOC_DRV_POL_N]);
	endproperty
	a_se_pol: assert property (p_se_pol) else $error("pin polarity wrong"); // R5
endmodule
`default_nettype wire

// ### cdoc_clock_sink.sv
// Downstream clock consumer that measures the half period of a received clock
`timescale 1ns/10ps
`default_nettype none
module cdoc_clock_sink (
	input wire logic clk, // Sampling clock
	input wire logic resetn, // Async active-low reset
	input wire logic clk_in, // Received clock pin
	output logic [15:0] half_period // Last half period in clk cycles
);
	// ****************************************
	// Toggle-to-toggle counter
	// ****************************************
	logic prev_r;
	logic [15:0] cnt_r;
	// Only a toggle closes a count, so a stuck clock never refreshes the result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_r <= 1'b0;
			cnt_r <= 16'h0000;
			half_period <= 16'h0000;
		end else begin
			prev_r <= clk_in;
			if (clk_in !== prev_r) begin
				half_period <= cnt_r;
				cnt_r <= 16'h0001;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the output clock path with a sink on each output
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk, resetn, reg_we, ref_sdm_en, fsel, ref_a, ref_b, il_raw, ol_raw;
	logic holdover, il_lock, ol_lock, legal, p_o, p_on, p_oep, p_oen, p_st;
	logic s_o, s_on, s_oep, s_oen, s_st;
	logic [1:0] p_fam, s_fam;
	logic [5:0] ref_int;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d0, d1, d2, fb_int, charge_pump;
	logic [15:0] tune_in, tune_word, hp1, hp2, e1, e2;
	logic [19:0] fb_frac, fb_mod, ref_frac, ref_mod, fb_frac_eff;
	logic [20:0] ref_frac_eff;
	logic [31:0] seed;
	int bad_count, n_tests;
	cdoc_clock_divider_output_config uut (.clk, .resetn, .reg_we, .reg_addr, .reg_wdata,
		.reg_rdata, .first_output_divider(d0), .second_output_divider(d1),
		.third_output_divider(d2), .fb_int, .fb_frac, .feedback_period_count(fb_mod),
		.ref_int, .ref_frac, .reference_period_count(ref_mod), .ref_sdm_en,
		.driver_family_select_pin(fsel), .ref_a_present(ref_a), .ref_b_present(ref_b),
		.in_loop_lock_raw(il_raw), .out_loop_lock_raw(ol_raw), .tune_word_in(tune_in),
		.tune_word, .holdover, .input_loop_locked(il_lock), .output_loop_locked(ol_lock),
		.settings_legal(legal), .ref_frac_eff, .fb_frac_eff, .charge_pump,
		.primary_clock_output(p_o), .primary_clock_output_n(p_on), .primary_oe_p(p_oep),
		.primary_oe_n(p_oen), .primary_family(p_fam), .primary_strong(p_st),
		.secondary_clock_output(s_o), .secondary_clock_output_n(s_on),
		.secondary_oe_p(s_oep), .secondary_oe_n(s_oen), .secondary_family(s_fam),
		.secondary_strong(s_st));
	cdoc_clock_sink sink1 (.clk, .resetn, .clk_in(p_o), .half_period(hp1));
	cdoc_clock_sink sink2 (.clk, .resetn, .clk_in(s_o), .half_period(hp2));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [1:0] oe_exp(input logic [2:0] m);
		case (m)
			3'h0, 3'h4, 3'h5: return 2'h3;
			3'h1: return 2'h2;
			3'h2: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction
	function automatic logic [1:0] fam_exp(input logic [2:0] m);
		return (m == 3'h4) ? 2'h1 : (m == 3'h5) ? 2'h2 : 2'h0;
	endfunction
	function automatic logic legal_exp();
		return d0 >= 8'h04 && d0 <= 8'h0B && d1 != 8'h00 && d1 <= 8'h3F && d2 != 8'h00
			&& d2 <= 8'h3F && fb_int >= 8'h40 && fb_mod != 20'h00000 && ref_mod != 20'h00000
			&& ref_mod < 20'h80000 && ref_int >= (ref_sdm_en ? 6'h03 : 6'h01);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_we = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		#1;
		chk("rdata", reg_rdata, e);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// A hang counts as a mismatch and still ends in the one closing report
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] ad [4];
		logic [7:0] v;
		logic [20:0] ex;
		int m, i;
		ad = '{8'h0A, 8'h32, 8'h34, 8'h33};
		seed = 32'h7994;
		bad_count = 0;
		n_tests = 0;
		resetn = 1'b0;
		{reg_we, reg_addr, reg_wdata, fsel, il_raw, ol_raw, tune_in} = '0;
		{d0, d1, d2, fb_int} = {8'h04, 8'h01, 8'h01, 8'h40};
		{fb_frac, fb_mod, ref_frac, ref_mod} = {20'h0, 20'h1, 20'h0, 20'h1};
		ref_int = 6'h01;
		ref_sdm_en = 1'b0;
		ref_a = 1'b1;
		ref_b = 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		foreach (ad[j]) rdc(ad[j], 8'h00);
		wr(8'h33, 8'hFF);
		rdc(8'h33, 8'h00);
		chk("rst", {il_lock, ol_lock, holdover, charge_pump}, 32'h0);
		for (m = 0; m < 4; m++) begin
			seed = xs(seed);
			v = (m == 0) ? 8'hFF : seed[7:0];
			wr(8'h0A, v);
			rdc(8'h0A, v);
			chk("cp", charge_pump, v);
		end
		$display("test registers done");
		for (m = 0; m < 8; m++) begin
			seed = xs(seed);
			v = {2'b10, m[2:0], seed[2:0]};
			wr(8'h32, v);
			wr(8'h34, v);
			cyc(2);
			rdc(8'h34, v);
			chk("oe", {p_oep, p_oen, s_oep, s_oen}, {2{oe_exp(m[2:0])}});
			if (m != 3 && m < 6) chk("fam", {p_fam, s_fam}, {2{fam_exp(m[2:0])}});
			if (m < 3 || m == 4) chk("strong", {p_st, s_st}, {2{seed[2]}});
			if (m == 0) chk("pol", {p_o ^ p_on, s_o ^ s_on}, {2{seed[0] ^ seed[1]}});
			wr(8'h32, v | 8'h40);
			cyc(2);
			chk("pdn", {p_oep, p_oen, p_fam}, 4'h3);
		end
		$display("test modes done");
		for (m = 0; m < 4; m++) begin
			seed = xs(seed);
			fsel = m[0];
			v = {2'b00, seed[5:0]};
			wr(8'h32, v);
			wr(8'h34, v);
			cyc(6);
			chk("pinfam", {p_fam, s_fam}, fsel ? 4'hA : 4'h5);
			chk("pinstr", {p_st, s_st}, fsel ? 2'h0 : {2{v[2]}});
		end
		$display("test pin select done");
		wr(8'h32, 8'h80);
		wr(8'h34, 8'h80);
		for (m = 0; m < 3; m++) begin
			seed = xs(seed);
			d0 = (m == 0) ? 8'h0B : 8'h04 + {6'h00, seed[1:0]};
			d1 = 8'h01 + {6'h00, seed[3:2]};
			d2 = 8'h01 + {6'h00, seed[5:4]};
			e1 = {8'h00, d0} * {8'h00, d1};
			e2 = e1 * {8'h00, d2};
			i = 0;
			while (i < 2000 && (hp1 !== e1 || hp2 !== e2)) begin
				@(negedge clk);
				i++;
			end
			chk("settle", {31'h0, i < 2000}, 32'h1);
			cyc(2 * e2 + 4);
			chk("half1", hp1, e1);
			chk("half2", hp2, e2);
		end
		$display("test dividers done");
		il_raw = 1'b1;
		ol_raw = 1'b1;
		cyc(1);
		chk("early", {il_lock, ol_lock}, 2'h0);
		cyc(3);
		chk("lock", {il_lock, ol_lock}, 2'h3);
		ol_raw = 1'b0;
		cyc(4);
		chk("unlock", {il_lock, ol_lock}, 2'h2);
		$display("test lock done");
		tune_in = 16'h5A3C;
		cyc(3);
		chk("tune", tune_word, 16'h5A3C);
		ref_a = 1'b0;
		cyc(4);
		chk("hold1", holdover, 1'b0);
		ref_b = 1'b0;
		cyc(4);
		chk("hold", holdover, 1'b1);
		for (m = 0; m < 4; m++) begin
			seed = xs(seed);
			tune_in = seed[15:0];
			cyc(1);
			chk("frozen", tune_word, 16'h5A3C);
		end
		chk("ilmask", il_lock, 1'b0);
		ref_b = 1'b1;
		cyc(4);
		chk("exit", holdover, 1'b0);
		cyc(1);
		chk("retune", tune_word, tune_in);
		$display("test holdover done");
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		cyc(1);
		chk("rst2", {holdover, il_lock, charge_pump, p_oep, p_oen}, 32'h3);
		cyc(1);
		chk("rst2hold", holdover, 1'b0);
		cyc(2);
		$display("test mid-run reset done");
		for (m = 0; m < 40; m++) begin
			seed = xs(seed);
			d0 = 8'h03 + {4'h0, seed[3:0] & (seed[29] ? 4'h9 : 4'h7)};
			d1 = (seed[4] & seed[5]) ? 8'h40 : {2'b00, seed[10:5]};
			d2 = (seed[11] & seed[12]) ? 8'h00 : {2'b00, seed[17:12]};
			ref_int = seed[18] ? {4'h0, seed[20:19]} : seed[26:21];
			ref_sdm_en = seed[27];
			fb_int = {seed[28] | seed[29], seed[26:20]};
			seed = xs(seed);
			fb_frac = seed[19:0];
			fb_mod = (seed[31] & seed[0]) ? 20'h00000 : seed[31:12];
			ref_frac = seed[25:6];
			ref_mod = {seed[30] & seed[1], seed[18:0]};
			#1;
			chk("legal", legal, legal_exp());
			cyc(2);
			ex = ref_sdm_en ? {1'b0, ref_mod} + {ref_frac[19], ref_frac} : 21'h0;
			chk("reff", ref_frac_eff, ex);
			chk("feff", fb_frac_eff, fb_frac);
		end
		$display("test settings done");
		give_verdict();
	end
endmodule
`default_nettype wire
